/* design/ifpu_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ifpu_top
	import ifpu_pkg::*;
(
	input  wire logic                       sys_clk,
	input  wire logic                       arst_n,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [ifpu_pkg::ADDR_W-1:0] paddr,
	input  wire logic [ifpu_pkg::DATA_W-1:0] pwdata,
	output logic                            pready,
	output logic      [ifpu_pkg::DATA_W-1:0] prdata,
	output logic                            pslverr,
	input  wire logic [ifpu_pkg::NUM_PINS-1:0] external_request_pin,
	input  wire logic [ifpu_pkg::NUM_PERIPH-1:0] periph_req,
	input  wire logic                       exc_ack,
	input  wire logic [ifpu_pkg::SRC_W-1:0]  exc_ack_source,
	output logic                            irq_pending,
	output logic      [ifpu_pkg::SRC_W-1:0]  irq_source,
	output logic                            irq_level
);
	import ifpu_pkg::*;

	// register state
	logic [7:0]          sense_q, sense_d;
	logic [7:0]          enable_q, enable_d;
	logic [7:0]          prio_a_q, prio_a_d;
	logic [7:0]          prio_b_q, prio_b_d;
	logic [NUM_PINS-1:0] armed_q, armed_d;

	// bus answer state
	logic                pready_q, pready_d;
	logic [DATA_W-1:0]   prdata_q, prdata_d;
	logic                pslverr_q, pslverr_d;

	// presented request
	logic                pend_q, pend_d;
	logic [SRC_W-1:0]    src_q, src_d;
	logic                lvl_q, lvl_d;

	logic [NUM_PINS-1:0] flags;
	logic [NUM_PINS-1:0] sw_clear;
	logic [NUM_PINS-1:0] pin_ack;
	logic [NUM_SRC-1:0]  src_req;
	logic [NUM_SRC-1:0]  src_level;
	logic                win_valid;
	logic [SRC_W-1:0]    win_id;
	logic                win_level;
	logic                access;
	logic                done;
	logic                mapped;
	logic                wr_done;
	logic                rd_done;

	// one wait state keeps every bus output straight from a flop
	assign access = psel & penable;
	assign done = access & pready_q;
	assign mapped = (paddr == ADDR_SENSE) | (paddr == ADDR_ENABLE) | (paddr == ADDR_FLAGS) |
	                (paddr == ADDR_PRIO_A) | (paddr == ADDR_PRIO_B);
	assign wr_done = done & pwrite & mapped;
	assign rd_done = done & ~pwrite & (paddr == ADDR_FLAGS);

	always_comb begin
		pready_d = access & ~pready_q;
		pslverr_d = access & ~pready_q & ~mapped;
		prdata_d = prdata_q;
		if (access & ~pready_q) begin
			prdata_d = '0;
			if (!pwrite) begin
				case (paddr)
					ADDR_SENSE:  prdata_d = {24'h000000, sense_q};
					ADDR_ENABLE: prdata_d = {24'h000000, enable_q};
					ADDR_FLAGS:  prdata_d = {26'h0000000, flags}; // R05
					ADDR_PRIO_A: prdata_d = {24'h000000, prio_a_q};
					ADDR_PRIO_B: prdata_d = {24'h000000, prio_b_q};
					default:     prdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_q <= 1'b0;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// register writes; a flag bit clears only if it was read as 1 since the last flag write
	always_comb begin
		sense_d = sense_q;
		enable_d = enable_q;
		prio_a_d = prio_a_q;
		prio_b_d = prio_b_q;
		armed_d = armed_q;
		sw_clear = '0;
		if (rd_done) begin
			armed_d = armed_q | prdata_q[NUM_PINS-1:0]; // R02
		end
		if (wr_done) begin
			case (paddr)
				ADDR_SENSE:  sense_d = pwdata[7:0];
				ADDR_ENABLE: enable_d = pwdata[7:0];
				ADDR_PRIO_A: prio_a_d = pwdata[7:0];
				ADDR_PRIO_B: prio_b_d = pwdata[7:0];
				ADDR_FLAGS: begin
					sw_clear = armed_q & ~pwdata[NUM_PINS-1:0]; // R02 R05
					armed_d = '0;
				end
				default: sense_d = sense_q;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sense_q <= RST_REG8;
			enable_q <= RST_REG8;
			prio_a_q <= RST_REG8; // R09
			prio_b_q <= RST_REG8; // R09
			armed_q <= RST_FLAGS;
		end else begin
			sense_q <= sense_d;
			enable_q <= enable_d;
			prio_a_q <= prio_a_d;
			prio_b_q <= prio_b_d;
			armed_q <= armed_d;
		end
	end

	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_ack
			assign pin_ack[p] = exc_ack & (exc_ack_source == SRC_W'(p));
		end
	endgenerate

	ifpu_flag_bank u_flags (
		.sys_clk              (sys_clk),
		.arst_n               (arst_n),
		.external_request_pin (external_request_pin),
		.pin_sense_select     (sense_q[NUM_PINS-1:0]),
		.sw_clear             (sw_clear),
		.exc_ack              (pin_ack),
		.pin_request_flag     (flags)
	);

	// source requests and their priority levels
	assign src_req = {periph_req, flags & enable_q[NUM_PINS-1:0]};
	assign src_level = {prio_b_q[PB_ADC], prio_b_q[PB_SCI1], prio_b_q[PB_SCI0], // R08
	                    prio_b_q[PB_DMA], prio_b_q[PB_TMR4],                     // R08
	                    prio_a_q[PA_TMR2], prio_a_q[PA_WDT],                     // R07
	                    prio_a_q[PA_PIN45], prio_a_q[PA_PIN45],                  // R07
	                    prio_a_q[PA_PIN23], prio_a_q[PA_PIN23],                  // R07
	                    prio_a_q[PA_PIN1], prio_a_q[PA_PIN0]};                   // R06 R07

	ifpu_prio_arbiter u_arb (
		.src_req   (src_req),
		.src_level (src_level),
		.win_valid (win_valid),
		.win_id    (win_id),
		.win_level (win_level)
	);

	always_comb begin
		pend_d = win_valid;
		src_d = win_id; // R10
		lvl_d = win_level & win_valid; // R06
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_q <= 1'b0;
			src_q <= '0;
			lvl_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
			src_q <= src_d;
			lvl_q <= lvl_d;
		end
	end

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign irq_pending = pend_q;
	assign irq_source = src_q;
	assign irq_level = lvl_q;

	a_write_one_nop: assert property (@(posedge sys_clk) disable iff (!arst_n) // R05
		wr_done && paddr == ADDR_FLAGS && pwdata[2] && flags[2] && !pin_ack[2] |=> flags[2])
		else $error("writing 1 cleared a pin flag");
	a_clear_needs_read: assert property (@(posedge sys_clk) disable iff (!arst_n) // R02
		wr_done && paddr == ADDR_FLAGS && !armed_q[2] && flags[2] && !pin_ack[2] |=> flags[2])
		else $error("flag cleared without a prior read of 1");
	a_flag_read_upper: assert property (@(posedge sys_clk) disable iff (!arst_n) // R05
		$rose(pready) && !pwrite && $past(paddr) == ADDR_FLAGS |-> prdata[7:6] == 2'b00)
		else $error("unused flag bits read nonzero");
	a_high_beats_low: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
		periph_req[0] && prio_a_q[PA_WDT] && (src_req[5:0] & src_level[5:0]) == 6'h00
		|=> irq_source == SRC_WDT && irq_level)
		else $error("high level watchdog request not presented first");
	a_prio_b_adc: assert property (@(posedge sys_clk) disable iff (!arst_n) // R08
		src_req[12] && prio_b_q[PB_ADC] && (src_req[11:0] & src_level[11:0]) == 12'h000
		|=> irq_level && irq_source == SRC_ADC)
		else $error("converter level not taken from register b bit 1");
	a_pin23_share: assert property (@(posedge sys_clk) disable iff (!arst_n) // R07
		src_level[2] == prio_a_q[PA_PIN23] && src_level[3] == prio_a_q[PA_PIN23] && src_level[0] == prio_a_q[PA_PIN0])
		else $error("pin priority mapping wrong");
	a_bus_wait_state: assert property (@(posedge sys_clk) disable iff (!arst_n)
		psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("bus answer not after exactly one wait state");

	// bus answer: one registered pulse per access, read data held between accesses
	a_pready_one_cycle: assert property (@(posedge sys_clk) disable iff (!arst_n)
		pready |=> !pready)
		else $error("pready stood longer than one cycle");
	a_err_with_ready: assert property (@(posedge sys_clk) disable iff (!arst_n)
		pslverr |-> pready)
		else $error("pslverr without pready");
	a_ready_in_access: assert property (@(posedge sys_clk) disable iff (!arst_n)
		pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_idle_no_ready: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!psel |=> !pready)
		else $error("pready raised without a selected transfer");
	a_unmapped_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
		access && !pready && !mapped |=> pslverr)
		else $error("unmapped access not answered with an error");
	a_mapped_no_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
		access && !pready && mapped |=> !pslverr)
		else $error("mapped access answered with an error");
	a_prdata_holds: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!(access && !pready) |=> $stable(prdata))
		else $error("read data changed outside an access");
	a_write_data_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		access && !pready && pwrite |=> prdata == 32'h00000000)
		else $error("write access returned nonzero read data");
	a_read_upper_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // R05
		pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read data bits nonzero");

	// register writes land only at the completing edge
	a_sense_write: assert property (@(posedge sys_clk) disable iff (!arst_n) // R01
		wr_done && paddr == ADDR_SENSE |=> sense_q == $past(pwdata[7:0]))
		else $error("sense select write lost");
	a_enable_write: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
		wr_done && paddr == ADDR_ENABLE |=> enable_q == $past(pwdata[7:0]))
		else $error("pin enable write lost");
	a_prio_a_write: assert property (@(posedge sys_clk) disable iff (!arst_n) // R07
		wr_done && paddr == ADDR_PRIO_A |=> prio_a_q == $past(pwdata[7:0]))
		else $error("priority register a write lost");
	a_prio_b_write: assert property (@(posedge sys_clk) disable iff (!arst_n) // R08
		wr_done && paddr == ADDR_PRIO_B |=> prio_b_q == $past(pwdata[7:0]))
		else $error("priority register b write lost");
	a_prio_idle_stable: assert property (@(posedge sys_clk) disable iff (!arst_n) // R06
		!wr_done |=> $stable(prio_a_q) && $stable(prio_b_q))
		else $error("priority changed without a write");
	a_mode_idle_stable: assert property (@(posedge sys_clk) disable iff (!arst_n) // R01
		!wr_done |=> $stable(sense_q) && $stable(enable_q))
		else $error("sense or enable changed without a write");

	// any flag write disarms every bit, so a stale read cannot clear a later request
	a_read_arms: assert property (@(posedge sys_clk) disable iff (!arst_n) // R02
		rd_done |=> armed_q == ($past(armed_q) | $past(prdata[NUM_PINS-1:0])))
		else $error("flag read did not arm the bits read as 1");
	a_write_disarms: assert property (@(posedge sys_clk) disable iff (!arst_n) // R02
		wr_done && paddr == ADDR_FLAGS |=> armed_q == 6'h00)
		else $error("flag write left bits armed");
	a_clear_only_armed: assert property (@(posedge sys_clk) disable iff (!arst_n) // R02
		(sw_clear & ~armed_q) == 6'h00)
		else $error("software clear of an unarmed flag");
	a_clear_only_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // R05
		wr_done && paddr == ADDR_FLAGS |-> (sw_clear & pwdata[NUM_PINS-1:0]) == 6'h00)
		else $error("writing 1 requested a clear");
	a_armed_clear_works: assert property (@(posedge sys_clk) disable iff (!arst_n) // R02
		wr_done && paddr == ADDR_FLAGS && armed_q[2] && !pwdata[2] &&
		(external_request_pin[2] || sense_q[2] && !$past(external_request_pin[2])) |=> !flags[2])
		else $error("armed flag not cleared by writing 0");
	a_periph_ack_ignored: assert property (@(posedge sys_clk) disable iff (!arst_n) // R03 R04
		exc_ack && exc_ack_source > 4'h5 |-> pin_ack == 6'h00)
		else $error("peripheral acknowledge reached a pin flag");

	// arbitration of the presented request
	a_idle_no_irq: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
		src_req == 13'h0000 |=> !irq_pending && !irq_level)
		else $error("request presented with none pending");
	a_level_only_pending: assert property (@(posedge sys_clk) disable iff (!arst_n) // R06
		irq_level |-> irq_pending)
		else $error("level 1 shown without a pending request");
	a_any_high_level: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
		|(src_req & src_level) |=> irq_level)
		else $error("level 1 request not presented first");
	a_all_low_level: assert property (@(posedge sys_clk) disable iff (!arst_n) // R06 R10
		src_req != 13'h0000 && (src_req & src_level) == 13'h0000 |=> irq_pending && !irq_level)
		else $error("level 0 request shown with level 1");
	a_pin0_high_wins: assert property (@(posedge sys_clk) disable iff (!arst_n) // R07
		src_req[0] && prio_a_q[PA_PIN0] |=> irq_level && irq_source == 4'h0)
		else $error("pin 0 at level 1 not presented");
	a_pin1_high_wins: assert property (@(posedge sys_clk) disable iff (!arst_n) // R07
		src_req[1] && prio_a_q[PA_PIN1] && !(src_req[0] && src_level[0]) |=> irq_level && irq_source == 4'h1)
		else $error("pin 1 at level 1 not presented");
	a_winner_stable: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
		$stable(src_req) && $stable(src_level) |=> $stable(irq_source))
		else $error("presented source changed with steady requests");
endmodule // ifpu_top
`default_nettype wire

/* design/ifpu_pkg.sv */
// Overview of operation
// [R01] pin flag sets on low level (sense 0) or falling edge (sense 1)
// [R02] software clears a flag by reading it as 1, then writing 0
// [R03] level sense: exception handling with pin high clears the flag
// [R04] edge sense: exception handling for the pin always clears the flag; a falling edge in the same cycle keeps it set
// [R05] flags in bits 5..0; writing 1 has no effect; bits 7..6 read 0
// [R06] priority bit 0 selects low level 0, bit 1 selects high level 1
// [R07] register A: b7 pin0, b6 pin1, b5 pins2-3, b4 pins4-5, b3 watchdog, b0 timer2
// [R08] register B: b6 timer4, b5 dma, b3 serial0, b2 serial1, b1 adc
// [R09] priority and flag registers reset to all zeros
// [R10] level-1 requests win over level-0; lower source id wins among equals
package ifpu_pkg;
	localparam int NUM_PINS = 6;
	localparam int NUM_PERIPH = 7;
	localparam int NUM_SRC = 13;
	localparam int SRC_W = 4;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_SENSE = 8'hF4;
	localparam logic [7:0] IDX_ENABLE = 8'hF5;
	localparam logic [7:0] IDX_FLAGS = 8'hF6;
	localparam logic [7:0] IDX_PRIO_A = 8'hF8;
	localparam logic [7:0] IDX_PRIO_B = 8'hF9;
	localparam logic [ADDR_W-1:0] ADDR_SENSE = {2'b00, IDX_SENSE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_ENABLE = {2'b00, IDX_ENABLE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = {2'b00, IDX_FLAGS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PRIO_A = {2'b00, IDX_PRIO_A, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PRIO_B = {2'b00, IDX_PRIO_B, 2'b00};

	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [5:0] RST_FLAGS = 6'h00;
	localparam logic [5:0] RST_PIN_PREV = 6'h3F;

	// priority bit positions
	localparam int PA_PIN0 = 7;
	localparam int PA_PIN1 = 6;
	localparam int PA_PIN23 = 5;
	localparam int PA_PIN45 = 4;
	localparam int PA_WDT = 3;
	localparam int PA_TMR2 = 0;
	localparam int PB_TMR4 = 6;
	localparam int PB_DMA = 5;
	localparam int PB_SCI0 = 3;
	localparam int PB_SCI1 = 2;
	localparam int PB_ADC = 1;

	// source ids: 0..5 pins, then on-chip sources
	localparam logic [SRC_W-1:0] SRC_WDT = 4'h6;
	localparam logic [SRC_W-1:0] SRC_TMR2 = 4'h7;
	localparam logic [SRC_W-1:0] SRC_TMR4 = 4'h8;
	localparam logic [SRC_W-1:0] SRC_DMA = 4'h9;
	localparam logic [SRC_W-1:0] SRC_SCI0 = 4'hA;
	localparam logic [SRC_W-1:0] SRC_SCI1 = 4'hB;
	localparam logic [SRC_W-1:0] SRC_ADC = 4'hC;
endpackage

/* design/ifpu_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module ifpu_flag_bank
	import ifpu_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire logic [NUM_PINS-1:0] external_request_pin,
	input  wire logic [NUM_PINS-1:0] pin_sense_select,
	input  wire logic [NUM_PINS-1:0] sw_clear,
	input  wire logic [NUM_PINS-1:0] exc_ack,
	output logic      [NUM_PINS-1:0] pin_request_flag
);
	logic [NUM_PINS-1:0] flag_q, flag_d;
	logic [NUM_PINS-1:0] prev_q, prev_d;
	logic [NUM_PINS-1:0] set_ev;

	genvar n;
	generate
		for (n = 0; n < NUM_PINS; n++) begin : g_pin
			always_comb begin
				set_ev[n] = pin_sense_select[n] ? (prev_q[n] & ~external_request_pin[n]) // R01
				                                : ~external_request_pin[n];               // R01
				prev_d[n] = external_request_pin[n];
				flag_d[n] = flag_q[n];
				if (sw_clear[n]) begin
					flag_d[n] = 1'b0; // R02
				end
				if (exc_ack[n] & (pin_sense_select[n] | external_request_pin[n])) begin
					flag_d[n] = 1'b0; // R03 R04
				end
				// a new request in the clearing cycle is kept
				if (set_ev[n]) begin
					flag_d[n] = 1'b1; // R01
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= RST_FLAGS; // R09
			prev_q <= RST_PIN_PREV;
		end else begin
			flag_q <= flag_d;
			prev_q <= prev_d;
		end
	end

	assign pin_request_flag = flag_q;

	a_edge_sets_flag: assert property (@(posedge sys_clk) disable iff (!arst_n) // R01
		pin_sense_select[2] && $past(external_request_pin[2]) && !external_request_pin[2]
		|=> pin_request_flag[2])
		else $error("falling edge did not set pin flag 2");
	a_level_holds_flag: assert property (@(posedge sys_clk) disable iff (!arst_n) // R01
		!pin_sense_select[0] && !external_request_pin[0] |=> pin_request_flag[0])
		else $error("low level did not set pin flag 0");
	a_edge_ack_clears: assert property (@(posedge sys_clk) disable iff (!arst_n) // R04
		pin_sense_select[2] && exc_ack[2] && !(prev_q[2] && !external_request_pin[2])
		|=> !pin_request_flag[2])
		else $error("edge-mode acknowledge did not clear pin flag 2");
	a_level_ack_keeps: assert property (@(posedge sys_clk) disable iff (!arst_n) // R03
		!pin_sense_select[3] && exc_ack[3] && !external_request_pin[3] |=> pin_request_flag[3])
		else $error("level-mode acknowledge cleared flag 3 while pin low");
endmodule // ifpu_flag_bank
`default_nettype wire

/* design/ifpu_prio_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module ifpu_prio_arbiter
	import ifpu_pkg::*;
(
	input  wire logic [NUM_SRC-1:0] src_req,
	input  wire logic [NUM_SRC-1:0] src_level,
	output logic                    win_valid,
	output logic      [SRC_W-1:0]   win_id,
	output logic                    win_level
);
	logic hi_found;
	logic lo_found;
	logic [SRC_W-1:0] hi_id;
	logic [SRC_W-1:0] lo_id;

	// scan downward so the lowest id is the last one written
	always_comb begin
		hi_found = 1'b0;
		lo_found = 1'b0;
		hi_id = '0;
		lo_id = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (src_req[i] && src_level[i]) begin
				hi_found = 1'b1;
				hi_id = SRC_W'(i);
			end
			if (src_req[i] && !src_level[i]) begin
				lo_found = 1'b1;
				lo_id = SRC_W'(i);
			end
		end
		win_valid = hi_found | lo_found;
		win_level = hi_found; // R10
		win_id = hi_found ? hi_id : lo_id; // R10
	end
endmodule // ifpu_prio_arbiter
`default_nettype wire

/* test/ifpu_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ifpu_partner
	import ifpu_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire logic [NUM_PINS-1:0] pin_lv,
	input  wire logic                ack_go,
	input  wire logic                irq_pending,
	input  wire logic [SRC_W-1:0]    irq_source,
	output logic      [NUM_PINS-1:0] external_request_pin,
	output logic                     exc_ack,
	output logic      [SRC_W-1:0]    exc_ack_source
);
	logic             ack_d;
	logic [SRC_W-1:0] src_d;

	assign external_request_pin = pin_lv;

	// one exception per cycle of ack_go while a request is pending; the source lines toggle when no ack is shown so a stale id never passes
	always_comb begin
		ack_d = ack_go && irq_pending;
		src_d = ack_d ? irq_source : ~exc_ack_source;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			exc_ack <= 1'b0;
			exc_ack_source <= 4'h0;
		end else begin
			exc_ack <= ack_d;
			exc_ack_source <= src_d;
		end
	end
endmodule // ifpu_partner
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ifpu_pkg::*;
	localparam logic [55:0] PVAL = 56'h02040820400108;
	logic                  sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0]     paddr;
	logic [DATA_W-1:0]     pwdata, prdata, rd;
	logic [NUM_PINS-1:0]   pin_lv, ext_pin;
	logic [NUM_PERIPH-1:0] periph_req;
	logic                  ack_go, exc_ack, irq_pending, irq_level;
	logic [SRC_W-1:0]      exc_src, irq_source;
	int                    errors, n_compared;

	ifpu_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.external_request_pin(ext_pin), .periph_req(periph_req), .exc_ack(exc_ack),
		.exc_ack_source(exc_src), .irq_pending(irq_pending), .irq_source(irq_source), .irq_level(irq_level));
	ifpu_partner partner (.sys_clk(sys_clk), .arst_n(arst_n), .pin_lv(pin_lv), .ack_go(ack_go),
		.irq_pending(irq_pending), .irq_source(irq_source), .external_request_pin(ext_pin),
		.exc_ack(exc_ack), .exc_ack_source(exc_src));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// pready and read data are taken at the rising edge that completes the access, then the request drops
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		bit ok;
		ok = 0;
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1;
		for (int i = 0; i < 16 && !ok; i++) begin
			@(posedge sys_clk);
			ok = pready;
		end
		if (!ok) begin
			errors++;
			$display("Error at %0t: no pready", $time);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic do_ack();
		@(posedge sys_clk);
		ack_go <= 1;
		@(posedge sys_clk);
		ack_go <= 0;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic t_regs();
		apb(0, ADDR_FLAGS, 0);
		check(rd, 0);
		apb(0, ADDR_PRIO_A, 0);
		check(rd, 0);
		apb(0, ADDR_PRIO_B, 0);
		check(rd, 0);
		check({irq_pending, irq_level}, 0);
		apb(0, 12'h000, 0);
		check(err, 1);
		check(rd, 0);
		apb(1, ADDR_PRIO_A, 8'hA5);
		apb(0, ADDR_PRIO_A, 0);
		check(rd, 32'hA5);
		apb(1, ADDR_PRIO_B, 8'h5A);
		apb(0, ADDR_PRIO_B, 0);
		check(rd, 32'h5A);
		apb(1, ADDR_PRIO_A, 8'h00);
		apb(1, ADDR_PRIO_B, 8'h00);
		$display("t_regs done");
	endtask

	task automatic t_level();
		apb(1, ADDR_ENABLE, 8'h3F);
		pin_lv[0] <= 0;
		repeat (3) @(posedge sys_clk);
		pin_lv[0] <= 1;
		repeat (3) @(posedge sys_clk);
		apb(0, ADDR_FLAGS, 0);
		check(rd, 32'h01);
		check({irq_pending, irq_source}, 5'h10);
		do_ack();
		apb(0, ADDR_FLAGS, 0);
		check(rd, 0);
		$display("t_level done");
	endtask

	task automatic t_edge();
		apb(1, ADDR_SENSE, 8'h04);
		pin_lv[2] <= 0;
		repeat (3) @(posedge sys_clk);
		apb(1, ADDR_FLAGS, 8'h00);
		apb(1, ADDR_FLAGS, 8'hFF);
		apb(0, ADDR_FLAGS, 0);
		check(rd, 32'h04);
		apb(1, ADDR_FLAGS, 8'h00);
		apb(0, ADDR_FLAGS, 0);
		check(rd, 0);
		pin_lv[2] <= 1;
		@(posedge sys_clk);
		pin_lv[2] <= 0;
		repeat (3) @(posedge sys_clk);
		check({irq_pending, irq_source}, 5'h12);
		do_ack();
		apb(0, ADDR_FLAGS, 0);
		check(rd, 0);
		pin_lv[2] <= 1;
		$display("t_edge done");
	endtask

	task automatic t_prio();
		apb(1, ADDR_SENSE, 8'h00);
		pin_lv <= 6'h36;
		apb(1, ADDR_PRIO_A, 8'h20);
		repeat (3) @(posedge sys_clk);
		check({irq_level, irq_source}, 5'h13);
		do_ack();
		apb(0, ADDR_FLAGS, 0);
		check(rd, 32'h09);
		apb(1, ADDR_PRIO_A, 8'h00);
		repeat (3) @(posedge sys_clk);
		check({irq_level, irq_source}, 5'h00);
		for (int j = 0; j < NUM_PERIPH; j++) begin
			periph_req <= 7'(1 << j);
			apb(1, j < 2 ? ADDR_PRIO_A : ADDR_PRIO_B, PVAL[8*j +: 8]);
			repeat (3) @(posedge sys_clk);
			check({irq_level, irq_source}, {1'b1, 4'(6 + j)});
			apb(1, j < 2 ? ADDR_PRIO_A : ADDR_PRIO_B, 8'h00);
			repeat (3) @(posedge sys_clk);
			check({irq_level, irq_source}, 5'h00);
		end
		periph_req <= 0;
		repeat (3) @(posedge sys_clk);
		check({irq_pending, irq_source}, 5'h10);
		apb(1, ADDR_ENABLE, 8'h00);
		repeat (3) @(posedge sys_clk);
		check({irq_pending, irq_level}, 0);
		pin_lv <= 6'h3F;
		$display("t_prio done");
	endtask

	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial begin
		errors = 0;
		n_compared = 0;
		arst_n = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		pin_lv = 6'h3F;
		periph_req = 0;
		ack_go = 0;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1;
		t_regs();
		t_level();
		t_edge();
		t_prio();
		test_done();
	end

	initial begin
		#100000;
		errors++;
		$display("Error at %0t: run timed out", $time);
		test_done();
	end
endmodule // testbench
`default_nettype wire
